/* File: ispme_ctrl.sv */
`timescale 1ns/10ps
module ispme_ctrl #(
	parameter int unsigned STAB_CYC = ispme_pkg::STAB_CYCLES
) (
	input wire logic REF_CLK_I,
	input wire logic RESET_I,
	input wire logic POR_I,
	input wire logic VPP_HIGH_I,
	input wire logic PIN_OUT_CFG_I,
	input wire ispme_pkg::ispme_req_t REQ_I,
	input wire logic [7:0] MEM_DATA_I,
	input wire logic [7:0] CMP_DATA_I,
	output logic PIN_OE_ALLOW_O,
	output logic ISP_MODE_O,
	output logic CPU_RUN_O,
	output logic BUSY_O,
	output logic DONE_O,
	output logic [7:0] OPT_ACTIVE_O,
	output logic [7:0] OPT_STORED_O,
	output logic [7:0] RD_DATA_O,
	output logic MISMATCH_O
);

	////////////////////////////////////////////////////////////////////////
	// State registers
	ispme_pkg::ispme_regs_t q; // Registered state
	ispme_pkg::ispme_regs_t d; // Next state
	logic locked; // Security lock from stored option
	logic [7:0] seen; // Data offered for comparison

	// Lock comes from the stored option byte
	assign locked = ~q.opt_stored[ispme_pkg::LOCK_BIT];
	// Locked part returns fixed data, not memory
	assign seen = locked ? ispme_pkg::LOCKED_DATA : MEM_DATA_I;

	////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		d = q;
		d.done = 1'b0;
		// Three-stage synchroniser for the high-voltage detector
		d.vpp_sync = {q.vpp_sync[1:0], VPP_HIGH_I};
		if (q.vpp_sync[2] == q.vpp_sync[1]) begin
			d.vpp_lvl = q.vpp_sync[1];
		end
		unique case (q.st)
			ispme_pkg::ISPME_ST_STAB: begin
				// Pin stays input while oscillator settles
				if (q.vpp_lvl) begin
					d.st = ispme_pkg::ISPME_ST_ISP;
				end else if (q.cnt >= 25'(STAB_CYC - 1)) begin
					d.st = ispme_pkg::ISPME_ST_RUN;
				end else begin
					d.cnt = q.cnt + 25'h000_0001;
				end
			end
			ispme_pkg::ISPME_ST_RUN: begin
				// Entry blocked while pin drives as output
				if (q.vpp_lvl && !PIN_OUT_CFG_I) begin
					d.st = ispme_pkg::ISPME_ST_ISP;
				end
			end
			ispme_pkg::ISPME_ST_ISP: begin
				// Only serial-port commands are serviced
				if (REQ_I.valid && REQ_I.cmd != ispme_pkg::ISPME_CMD_NONE) begin
					d.st = ispme_pkg::ISPME_ST_BUSY;
					d.mismatch = 1'b0;
					unique case (REQ_I.cmd)
						ispme_pkg::ISPME_CMD_ERASE:
							d.opt_stored = ispme_pkg::OPT_ERASED;
						ispme_pkg::ISPME_CMD_OPTWR:
							d.opt_stored = REQ_I.opt;
						ispme_pkg::ISPME_CMD_VERIFY:
							d.mismatch = (seen != CMP_DATA_I);
						ispme_pkg::ISPME_CMD_READ:
							d.rd_data = seen;
						default: begin
						end
					endcase
				end
			end
			ispme_pkg::ISPME_ST_BUSY: begin
				// Command finished: resume user code on its own
				d.st = ispme_pkg::ISPME_ST_RUN;
				d.done = 1'b1;
			end
			default: d.st = ispme_pkg::ISPME_ST_STAB;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// State register; power-on reset also restarts stabilization
	always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			q <= '{st: ispme_pkg::ISPME_ST_STAB, cnt: 25'h000_0000,
				vpp_sync: 3'h0, vpp_lvl: 1'b0,
				opt_stored: ispme_pkg::OPT_ERASED,
				opt_active: ispme_pkg::OPT_ERASED, done: 1'b0,
				rd_data: 8'h00, mismatch: 1'b0};
		end else begin
			q <= d;
			// Options copied to active set only at power-on
			if (POR_I) begin
				q.opt_active <= d.opt_stored;
				q.st <= ispme_pkg::ISPME_ST_STAB;
				q.cnt <= 25'h000_0000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign PIN_OE_ALLOW_O = (q.st != ispme_pkg::ISPME_ST_STAB);
	assign ISP_MODE_O = (q.st == ispme_pkg::ISPME_ST_ISP) ||
		(q.st == ispme_pkg::ISPME_ST_BUSY);
	assign CPU_RUN_O = (q.st == ispme_pkg::ISPME_ST_RUN);
	assign BUSY_O = (q.st == ispme_pkg::ISPME_ST_BUSY);
	assign DONE_O = q.done;
	assign OPT_ACTIVE_O = q.opt_active;
	assign OPT_STORED_O = q.opt_stored;
	assign RD_DATA_O = q.rd_data;
	assign MISMATCH_O = q.mismatch;

	////////////////////////////////////////////////////////////////////////
	// Assertions
	property p_out_blocks;
		@(posedge REF_CLK_I) disable iff (RESET_I)
		(q.st == ispme_pkg::ISPME_ST_RUN && PIN_OUT_CFG_I && !POR_I)
			|=> !ISP_MODE_O;
	endproperty
	a_out_blocks: assert property (p_out_blocks) else $error("entry while output");

	property p_enter;
		@(posedge REF_CLK_I) disable iff (RESET_I)
		(q.st == ispme_pkg::ISPME_ST_RUN && q.vpp_lvl && !PIN_OUT_CFG_I
			&& !POR_I) |=> ISP_MODE_O;
	endproperty
	a_enter: assert property (p_enter) else $error("no programming entry");

	property p_stab_input;
		@(posedge REF_CLK_I) disable iff (RESET_I)
		(q.st == ispme_pkg::ISPME_ST_STAB) |-> !PIN_OE_ALLOW_O;
	endproperty
	a_stab_input: assert property (p_stab_input) else $error("pin driven early");

	property p_opt_hold;
		@(posedge REF_CLK_I) disable iff (RESET_I)
		!POR_I |=> $stable(OPT_ACTIVE_O);
	endproperty
	a_opt_hold: assert property (p_opt_hold) else $error("option changed late");

	property p_exit;
		@(posedge REF_CLK_I) disable iff (RESET_I)
		(BUSY_O && !POR_I) |=> (CPU_RUN_O && DONE_O);
	endproperty
	a_exit: assert property (p_exit) else $error("did not resume");

	property p_erase;
		@(posedge REF_CLK_I) disable iff (RESET_I)
		(q.st == ispme_pkg::ISPME_ST_ISP && REQ_I.valid && !POR_I &&
			REQ_I.cmd == ispme_pkg::ISPME_CMD_ERASE)
			|=> OPT_STORED_O == ispme_pkg::OPT_ERASED;
	endproperty
	a_erase: assert property (p_erase) else $error("erase kept option");

	property p_lock;
		@(posedge REF_CLK_I) disable iff (RESET_I)
		(q.st == ispme_pkg::ISPME_ST_ISP && REQ_I.valid && locked && !POR_I
			&& REQ_I.cmd == ispme_pkg::ISPME_CMD_READ)
			|=> RD_DATA_O == ispme_pkg::LOCKED_DATA;
	endproperty
	a_lock: assert property (p_lock) else $error("locked data leaked");

	property p_suspend;
		@(posedge REF_CLK_I) disable iff (RESET_I)
		ISP_MODE_O |-> !CPU_RUN_O;
	endproperty
	a_suspend: assert property (p_suspend) else $error("user code ran");

	// Completion strobe lasts exactly one cycle
	property p_done_pulse;
		@(posedge REF_CLK_I) disable iff (RESET_I)
		DONE_O |=> !DONE_O;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done held");

	// Locked part must fail verify against real data
	property p_verify_lock;
		@(posedge REF_CLK_I) disable iff (RESET_I)
		(q.st == ispme_pkg::ISPME_ST_ISP && REQ_I.valid && locked && !POR_I
			&& REQ_I.cmd == ispme_pkg::ISPME_CMD_VERIFY
			&& CMP_DATA_I != ispme_pkg::LOCKED_DATA) |=> MISMATCH_O;
	endproperty
	a_verify_lock: assert property (p_verify_lock) else $error("verify passed");

	// Pin stays input until the window has run out or high voltage ends it early
	property p_stab_hold;
		@(posedge REF_CLK_I) disable iff (RESET_I)
		(q.st == ispme_pkg::ISPME_ST_STAB && !q.vpp_lvl && !POR_I
			&& q.cnt < 25'(STAB_CYC - 1)) |=> !PIN_OE_ALLOW_O;
	endproperty
	a_stab_hold: assert property (p_stab_hold) else $error("window cut short");

	// Commands outside programming mode are ignored
	property p_refuse;
		@(posedge REF_CLK_I) disable iff (RESET_I)
		(q.st == ispme_pkg::ISPME_ST_RUN && REQ_I.valid && !POR_I)
			|=> !BUSY_O;
	endproperty
	a_refuse: assert property (p_refuse) else $error("command ran in run");

endmodule : ispme_ctrl

/* File: ispme_pkg.sv */
package ispme_pkg;

	// Power-on oscillator stabilization time in ns
	localparam int unsigned STAB_TIME_NS = 20_000_000;
	// Clock period in ns
	localparam int unsigned CLK_PERIOD_NS = 10;
	// Stabilization window in cycles, rounded up
	localparam int unsigned STAB_CYCLES =
		(STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Option configuration width and unconfigured (erased) value
	localparam int unsigned OPT_W = 8;
	localparam logic [7:0] OPT_ERASED = 8'hFF;
	// Memory data width and value returned when locked
	localparam int unsigned DATA_W = 8;
	localparam logic [7:0] LOCKED_DATA = 8'h00;
	// Bit of the option byte that holds the security lock
	localparam int unsigned LOCK_BIT = 4;

	// Programming commands received on the serial port
	typedef enum logic [2:0] {
		ISPME_CMD_NONE = 3'h0,
		ISPME_CMD_ERASE = 3'h1,
		ISPME_CMD_PROGRAM = 3'h2,
		ISPME_CMD_VERIFY = 3'h3,
		ISPME_CMD_OPTWR = 3'h4,
		ISPME_CMD_READ = 3'h5
	} ispme_cmd_t;

	// Operating modes, one-hot
	typedef enum logic [3:0] {
		ISPME_ST_STAB = 4'b0001,
		ISPME_ST_RUN = 4'b0010,
		ISPME_ST_ISP = 4'b0100,
		ISPME_ST_BUSY = 4'b1000
	} ispme_state_t;

	// Command request from the serial port
	typedef struct packed {
		logic valid;
		ispme_cmd_t cmd;
		logic [7:0] opt;
	} ispme_req_t;

	// Whole state of the controller
	typedef struct packed {
		ispme_state_t st;
		logic [24:0] cnt;
		logic [2:0] vpp_sync;
		logic vpp_lvl;
		logic [7:0] opt_stored;
		logic [7:0] opt_active;
		logic done;
		logic [7:0] rd_data;
		logic mismatch;
	} ispme_regs_t;

endpackage : ispme_pkg

/* File: ispme_adapter.sv */
`timescale 1ns/10ps
// Programming adapter: drives the high voltage and serial_port commands
module ispme_adapter (
	input wire logic clk_i,
	output logic vpp_o,
	output ispme_pkg::ispme_req_t req_o
);
	// Idle: pull-down keeps the pin low, no command pending
	initial begin
		vpp_o = 1'b0;
		req_o = '0;
	end
	// Raise or drop the high voltage at the next falling clock edge
	// Callers raise it during stabilization and in normal run, both times with the pin set as output
	task automatic set_vpp(input logic v);
		@(negedge clk_i);
		vpp_o = v;
	endtask : set_vpp
	// One command pulse; auto order is kept by the caller
	task automatic send(input ispme_pkg::ispme_cmd_t c, input logic [7:0] o);
		@(negedge clk_i);
		req_o = '{valid: 1'b1, cmd: c, opt: o};
		@(negedge clk_i);
		// Released: operand lines show a changed value
		req_o.valid = 1'b0;
		req_o.opt = ~o;
	endtask : send
endmodule : ispme_adapter

/* File: ispme_ctrl_test.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
	$display("ERROR %0t got %h want %h", $time, a, b); end end
module ispme_ctrl_test;
	logic clk, rst, por, cfg;
	logic [7:0] mem, cmp, opt_a, opt_s, rd;
	logic oe, isp, run, busy, done, mis;
	logic vpp;
	ispme_pkg::ispme_req_t req;
	int fail_count = 0;
	int n_checks = 0;
	int cyc = 0;
	ispme_adapter i_adp (.clk_i(clk), .vpp_o(vpp), .req_o(req));
	ispme_ctrl #(.STAB_CYC(16)) i_dut (.REF_CLK_I(clk), .RESET_I(rst),
		.POR_I(por), .VPP_HIGH_I(vpp), .PIN_OUT_CFG_I(cfg), .REQ_I(req),
		.MEM_DATA_I(mem), .CMP_DATA_I(cmp), .PIN_OE_ALLOW_O(oe),
		.ISP_MODE_O(isp), .CPU_RUN_O(run), .BUSY_O(busy), .DONE_O(done),
		.OPT_ACTIVE_O(opt_a), .OPT_STORED_O(opt_s), .RD_DATA_O(rd),
		.MISMATCH_O(mis));
	////////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d errors %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up
	// Bounded wait for programming mode
	task automatic wait_isp();
		for (int i = 0; i < 20 && isp !== 1'b1; i++)
			@(negedge clk);
	endtask : wait_isp
	// One command, then return to run and re-entry while the pin stays high
	task automatic do_cmd(input ispme_pkg::ispme_cmd_t c, input logic [7:0] o);
		i_adp.send(c, o);
		`CHK(busy, 1'b1)
		@(negedge clk);
		`CHK({done, run, isp}, 3'b110)
		wait_isp();
		`CHK(isp, 1'b1)
	endtask : do_cmd
	////////////////////////////////////////////////////////////////////////
	// Entry during stabilization with the pin set as output
	task automatic t_stab();
		`CHK(oe, 1'b0)
		i_adp.set_vpp(1'b1);
		wait_isp();
		`CHK({isp, run}, 2'b10)
		cfg = 1'b0;
	endtask : t_stab
	// Auto order, then locked verify and read
	task automatic t_auto();
		do_cmd(ispme_pkg::ISPME_CMD_ERASE, 8'h00);
		`CHK(opt_s, 8'hFF)
		do_cmd(ispme_pkg::ISPME_CMD_PROGRAM, 8'h00);
		do_cmd(ispme_pkg::ISPME_CMD_VERIFY, 8'h00);
		`CHK(mis, 1'b0)
		do_cmd(ispme_pkg::ISPME_CMD_OPTWR, 8'hEF);
		`CHK({opt_s, opt_a}, 16'hEF_FF)
		do_cmd(ispme_pkg::ISPME_CMD_VERIFY, 8'h00);
		`CHK(mis, 1'b1)
		do_cmd(ispme_pkg::ISPME_CMD_READ, 8'h00);
		`CHK(rd, ispme_pkg::LOCKED_DATA)
	endtask : t_auto
	// Power cycle latches options; output pin blocks entry; run refuses
	task automatic t_por();
		i_adp.set_vpp(1'b0);
		repeat (6) @(negedge clk);
		por = 1'b1;
		@(negedge clk);
		por = 1'b0;
		repeat (24) @(negedge clk);
		`CHK({opt_a, oe, run}, 10'b1110_1111_11)
		cfg = 1'b1;
		i_adp.set_vpp(1'b1);
		repeat (10) @(negedge clk);
		`CHK(isp, 1'b0)
		i_adp.send(ispme_pkg::ISPME_CMD_ERASE, 8'h00);
		`CHK({busy, opt_s}, 9'h0EF)
	endtask : t_por
	initial begin
		rst = 1'b1;
		por = 1'b0;
		cfg = 1'b1;
		mem = 8'h5A;
		cmp = 8'h5A;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		t_stab();
		t_auto();
		t_por();
		wrap_up();
	end
endmodule : ispme_ctrl_test
